// ==== hdl/mmbd_data_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mmbd_regs.svh"

// ----------------------------------------------------------------
// General RAM with bank 1 mirror of the top 16 bytes
// ----------------------------------------------------------------
module mmbd_data_mem
(
  input  wire logic       clk,
  input  wire logic       bank,
  input  wire logic [6:0] ofs,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);

  // Bank 0 also owns the shared top 16 bytes, so it is the larger array
  logic [7:0] bank0 [`MMBD_RAM0_BYTES + `MMBD_MIRROR_BYTES];
  logic [7:0] bank1 [`MMBD_RAM1_BYTES];
  logic [6:0] rel;
  logic       to_b0;

  // Mirror area always lands in bank 0 storage
  assign to_b0 = !bank || (ofs >= `MMBD_MIRROR_BASE);
  assign rel   = ofs - `MMBD_RAM_BASE;

  always_comb
  begin
    if (to_b0)
      rd_data = bank0[rel];
    else
      rd_data = bank1[rel[4:0]];
  end

  always_ff @(posedge clk)
  begin
    if (wr_en && to_b0)
      bank0[rel] <= wr_data;
    else if (wr_en)
      bank1[rel[4:0]] <= wr_data;
  end

endmodule : mmbd_data_mem
`default_nettype wire

// ==== hdl/mmbd_pkg.sv ====
`default_nettype none

package mmbd_pkg;

  // Class of a decoded data address
  typedef enum logic [3:0]
  {
    MMBD_CORE    = 4'b0001,
    MMBD_RAM     = 4'b0010,
    MMBD_SPECIAL = 4'b0100,
    MMBD_UNIMP   = 4'b1000
  } mmbd_region_t;

endpackage : mmbd_pkg

`default_nettype wire

// ==== hdl/mmbd_prog_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mmbd_regs.svh"

// ----------------------------------------------------------------
// Program store with its own port
// ----------------------------------------------------------------
module mmbd_prog_mem
(
  input  wire logic        clk,
  input  wire logic [12:0] fetch_addr,
  output logic      [13:0] fetch_word,
  input  wire logic        load_en,
  input  wire logic [12:0] load_addr,
  input  wire logic [13:0] load_word
);

  logic [13:0] store [`MMBD_PROG_WORDS];

  // Upper two address bits dropped, so fetches wrap
  always_ff @(posedge clk)
  begin
    if (load_en)
      store[load_addr[10:0]] <= load_word;
    fetch_word <= store[fetch_addr[10:0]];
  end

endmodule : mmbd_prog_mem
`default_nettype wire

// ==== hdl/mmbd_regs.svh ====
`ifndef MMBD_REGS_SVH
`define MMBD_REGS_SVH

// ----------------------------------------------------------------
// Register offsets within a bank
// ----------------------------------------------------------------
`define MMBD_OFS_INDIRECT   7'h00
`define MMBD_OFS_PC_LOW     7'h02
`define MMBD_OFS_STATUS     7'h03
`define MMBD_OFS_POINTER    7'h04
`define MMBD_OFS_PC_HIGH    7'h0A
`define MMBD_OFS_INTCTL     7'h0B

// ----------------------------------------------------------------
// Layout of data space
// ----------------------------------------------------------------
`define MMBD_RAM_BASE       7'h20
`define MMBD_MIRROR_BASE    7'h70
`define MMBD_BANK_BYTES     128
`define MMBD_RAM0_BYTES     80
`define MMBD_RAM1_BYTES     32
`define MMBD_MIRROR_BYTES   16
`define MMBD_B1_RAM_END     7'h3F

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define MMBD_ST_BANK_HI     6
`define MMBD_ST_BANK_LO     5
`define MMBD_STATUS_RST     8'h18
`define MMBD_PC_RST         13'h0000
`define MMBD_PC_IRQ         13'h0004
`define MMBD_PROG_WORDS     2048

// ----------------------------------------------------------------
// APB map (byte addresses)
// ----------------------------------------------------------------
`define MMBD_APB_CTRL       12'h000
`define MMBD_APB_PC         12'h004
`define MMBD_APB_STATUS     12'h008
`define MMBD_APB_DADDR      12'h00C
`define MMBD_APB_DDATA      12'h010
`define MMBD_APB_PADDR      12'h014
`define MMBD_APB_PDATA      12'h018

`endif

// ==== hdl/mmbd_top.sv ====
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "mmbd_regs.svh"

// Notes on behaviour
// - Program fetch and data access use separate ports in one cycle.
// - The program counter is 13 bits over an 8K by 14 space.
// - Only 2K words exist and higher fetch addresses wrap onto them.
// - After reset fetching starts at address zero.
// - A taken interrupt redirects fetching to address four.
// - Status bits 6 and 5 choose the bank, 00 bank 0 and 01 bank 1.
// - Each bank spans 128 bytes, offsets 00h to 7Fh.
// - Low offsets are control registers, higher ones general RAM.
// - Offsets 70h-7Fh and some core registers show in both banks.
// - RAM is reached directly with the bank or through the pointer.
// - Control registers are storage cells read and written as data.
// - Core registers answer at their offset in any bank.
// - Unimplemented data locations read as zero.
module mmbd_top
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [12:0] FETCH_PC,
  output logic      [13:0] FETCH_WORD
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic mmbd_pkg::mmbd_region_t region_of
  (
    input logic       bank_hi,
    input logic       bank,
    input logic [6:0] ofs
  );
    if (ofs == `MMBD_OFS_INDIRECT || ofs == `MMBD_OFS_PC_LOW ||
        ofs == `MMBD_OFS_STATUS   || ofs == `MMBD_OFS_POINTER ||
        ofs == `MMBD_OFS_PC_HIGH  || ofs == `MMBD_OFS_INTCTL)
      region_of = mmbd_pkg::MMBD_CORE;
    else if (bank_hi)
      region_of = mmbd_pkg::MMBD_UNIMP;
    else if (ofs < `MMBD_RAM_BASE)
      region_of = mmbd_pkg::MMBD_SPECIAL;
    else if (bank && ofs > `MMBD_B1_RAM_END && ofs < `MMBD_MIRROR_BASE)
      region_of = mmbd_pkg::MMBD_UNIMP;
    else
      region_of = mmbd_pkg::MMBD_RAM;
  endfunction : region_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  status;
  logic [7:0]  pointer;
  logic [4:0]  pc_high_latch;
  logic [7:0]  intctl;
  logic [12:0] pc;
  logic [7:0]  ctrl_cells [2][32];
  logic        run;
  logic        irq;
  logic        prog_load;
  logic [12:0] prog_addr;
  logic [13:0] prog_word;
  logic [7:0]  d_addr;
  logic        d_ind;

  logic        apb_wr;
  logic        apb_rd;
  logic [7:0]  eff_addr;
  logic        eff_bank;
  logic [6:0]  eff_ofs;
  logic        eff_hi;
  logic        d_wr;
  logic [7:0]  d_wdata;
  logic [7:0]  d_rdata;
  logic [7:0]  ram_rdata;
  logic        ram_wr;
  logic [13:0] word;
  mmbd_pkg::mmbd_region_t reg_cls;

  // Zero wait state slave; answer in the access cycle
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && !PENABLE && !PWRITE;

  // Indirect goes through the pointer, direct through the bank bits
  always_comb
  begin
    if (d_addr[6:0] == `MMBD_OFS_INDIRECT && !d_ind)
      eff_addr = pointer;
    else
      eff_addr = {status[`MMBD_ST_BANK_LO], d_addr[6:0]};
  end

  assign eff_ofs  = eff_addr[6:0];
  assign eff_bank = eff_addr[7];
  assign eff_hi   = (d_addr[6:0] == `MMBD_OFS_INDIRECT && !d_ind) ?
                    1'b0 : status[`MMBD_ST_BANK_HI];
  assign reg_cls  = region_of(eff_hi, eff_bank, eff_ofs);
  assign d_wdata  = PWDATA[7:0];
  assign d_wr     = apb_wr && (PADDR == `MMBD_APB_DDATA);
  assign ram_wr   = d_wr && reg_cls == mmbd_pkg::MMBD_RAM;

  // ----------------------------------------------------------------
  // Data read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    d_rdata = 8'h00;
    unique case (reg_cls)
      mmbd_pkg::MMBD_CORE:
        unique case (eff_ofs)
          `MMBD_OFS_PC_LOW:  d_rdata = pc[7:0];
          `MMBD_OFS_STATUS:  d_rdata = status;
          `MMBD_OFS_POINTER: d_rdata = pointer;
          `MMBD_OFS_PC_HIGH: d_rdata = {3'h0, pc_high_latch};
          `MMBD_OFS_INTCTL:  d_rdata = intctl;
          default:           d_rdata = 8'h00;  // Pointer to itself
        endcase
      mmbd_pkg::MMBD_SPECIAL:
        d_rdata = ctrl_cells[eff_bank][eff_ofs[4:0]];
      mmbd_pkg::MMBD_RAM:   d_rdata = ram_rdata;
      mmbd_pkg::MMBD_UNIMP: d_rdata = 8'h00;
      default:              d_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      status  <= `MMBD_STATUS_RST;
      pointer <= 8'h00;
      pc_high_latch <= 5'h00;
      intctl  <= 8'h00;
    end
    else if (d_wr && reg_cls == mmbd_pkg::MMBD_CORE)
    begin
      unique case (eff_ofs)
        `MMBD_OFS_STATUS:  status  <= d_wdata;
        `MMBD_OFS_POINTER: pointer <= d_wdata;
        `MMBD_OFS_PC_HIGH: pc_high_latch <= d_wdata[4:0];
        `MMBD_OFS_INTCTL:  intctl  <= d_wdata;
        default:           pointer <= pointer;
      endcase
    end
  end

  // Peripheral cells kept as plain storage; their behaviour is elsewhere
  always_ff @(posedge SYS_CLK)
  begin
    if (d_wr && reg_cls == mmbd_pkg::MMBD_SPECIAL)
      ctrl_cells[eff_bank][eff_ofs[4:0]] <= d_wdata;
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
      pc <= `MMBD_PC_RST;
    else if (irq)
      pc <= `MMBD_PC_IRQ;
    else if (d_wr && reg_cls == mmbd_pkg::MMBD_CORE &&
             eff_ofs == `MMBD_OFS_PC_LOW)
      pc <= {pc_high_latch, d_wdata};
    else if (run)
      pc <= pc + 13'h0001;
  end

  // ----------------------------------------------------------------
  // APB control and debug registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      run       <= 1'b0;
      irq       <= 1'b0;
      prog_load <= 1'b0;
      prog_addr <= 13'h0000;
      prog_word <= 14'h0000;
      d_addr    <= 8'h00;
      d_ind     <= 1'b0;
    end
    else
    begin
      irq       <= apb_wr && PADDR == `MMBD_APB_CTRL && PWDATA[1];
      prog_load <= apb_wr && PADDR == `MMBD_APB_PDATA;
      if (apb_wr && PADDR == `MMBD_APB_CTRL)
        run <= PWDATA[0];
      if (apb_wr && PADDR == `MMBD_APB_DADDR)
      begin
        d_addr <= PWDATA[7:0];
        d_ind  <= PWDATA[8];
      end
      if (apb_wr && PADDR == `MMBD_APB_PADDR)
        prog_addr <= PWDATA[12:0];
      if (apb_wr && PADDR == `MMBD_APB_PDATA)
        prog_word <= PWDATA[13:0];
    end
  end

  // Read data registered in setup, valid at access phase
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && PADDR > `MMBD_APB_PDATA;
      if (apb_rd)
      begin
        unique case (PADDR)
          `MMBD_APB_CTRL:   PRDATA <= {31'h0, run};
          `MMBD_APB_PC:     PRDATA <= {19'h0, pc};
          `MMBD_APB_STATUS: PRDATA <= {24'h0, status};
          `MMBD_APB_DADDR:  PRDATA <= {23'h0, d_ind, d_addr};
          `MMBD_APB_DDATA:  PRDATA <= {24'h0, d_rdata};
          `MMBD_APB_PADDR:  PRDATA <= {19'h0, prog_addr};
          `MMBD_APB_PDATA:  PRDATA <= {18'h0, word};
          default:          PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Fetch observed on its own outputs, independent of data traffic
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      FETCH_PC   <= 13'h0000;
      FETCH_WORD <= 14'h0000;
    end
    else
    begin
      FETCH_PC   <= pc;
      FETCH_WORD <= word;
    end
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  mmbd_prog_mem u_prog
  (
    .clk        (SYS_CLK),
    .fetch_addr (pc),
    .fetch_word (word),
    .load_en    (prog_load),
    .load_addr  (prog_addr),
    .load_word  (prog_word)
  );

  mmbd_data_mem u_data
  (
    .clk     (SYS_CLK),
    .bank    (eff_bank),
    .ofs     (eff_ofs),
    .wr_en   (ram_wr),
    .wr_data (d_wdata),
    .rd_data (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RESET_PC: assert property (@(posedge SYS_CLK)
    !RST_B |=> pc == 13'h0000)
    else $error("pc not zero after reset");

  AST_IRQ_VEC: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    irq |=> pc == 13'h0004)
    else $error("interrupt did not vector to four");

  AST_UNIMP_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    reg_cls == mmbd_pkg::MMBD_UNIMP |-> d_rdata == 8'h00)
    else $error("unimplemented read not zero");

  AST_HI_BANK: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (eff_hi && eff_ofs >= 7'h20) |-> reg_cls == mmbd_pkg::MMBD_UNIMP)
    else $error("bank 2 or 3 decoded as present");

  AST_CORE_ANY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    eff_ofs == 7'h03 |-> d_rdata == status)
    else $error("status not visible in this bank");

  AST_IND: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (d_addr[6:0] == 7'h00 && !d_ind) |-> eff_addr == pointer)
    else $error("indirect port ignored the pointer");

  AST_PC_STEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (run && !irq && !d_wr) ##1 RST_B |-> pc == $past(pc) + 13'h0001)
    else $error("pc did not advance");

  AST_READY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("apb answer late");

endmodule : mmbd_top
`default_nettype wire

// ==== tb/mmbd_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Core side bus master
// ----------------------------------------------------------------
module mmbd_core_model
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in this time step
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q,
                    output logic e);
    xfer(1'b0, a, 32'h00000000, q, e);
  endtask : rd
endmodule : mmbd_core_model

`default_nettype wire

// ==== tb/mmbd_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mmbd_regs.svh"

module mmbd_tb;
  logic        sys_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  logic [12:0] fetch_pc;
  logic [13:0] fetch_word;
  int          err_total;
  int          n_checks;

  mmbd_top mmbd_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FETCH_PC(fetch_pc), .FETCH_WORD(fetch_word));

  mmbd_core_model mmbd_core_model_inst (.clk(sys_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // Clock, 40 ns period
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
    mmbd_core_model_inst.rd(a, rdat, rerr);
    chk(nm, rdat, exp);
  endtask : rdchk

  // Data space access through address and data port
  task automatic dw(input logic [7:0] o, input logic [7:0] v);
    mmbd_core_model_inst.wr(`MMBD_APB_DADDR, {24'h000000, o});
    mmbd_core_model_inst.wr(`MMBD_APB_DDATA, {24'h000000, v});
  endtask : dw

  task automatic dr(input string nm, input logic [7:0] o,
                    input logic [7:0] exp);
    mmbd_core_model_inst.wr(`MMBD_APB_DADDR, {24'h000000, o});
    rdchk(nm, `MMBD_APB_DDATA, {24'h000000, exp});
  endtask : dr

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #2000000;
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    n_checks  = 0;
    rst_b     = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdchk("pc_reset", `MMBD_APB_PC, 32'h00000000);
    rdchk("status_reset", `MMBD_APB_STATUS, 32'h00000018);
    dw(8'h20, 8'hA5);
    // Bank 1 with the high select bit kept clear
    dw(8'h03, 8'h38);
    rdchk("status_bank1", `MMBD_APB_STATUS, 32'h00000038);
    dw(8'h20, 8'h5A);
    dw(8'h70, 8'h3C);
    dw(8'h04, 8'h20);
    dr("b1_ram", 8'h20, 8'h5A);
    dr("b1_gap", 8'h40, 8'h00);
    dw(8'h03, 8'h18);
    dr("b0_ram", 8'h20, 8'hA5);
    dr("mirror", 8'h70, 8'h3C);
    dr("ptr_any_bank", 8'h04, 8'h20);
    dr("ind_b0", 8'h00, 8'hA5);
    dw(8'h04, 8'hA0);
    dr("ind_b1", 8'h00, 8'h5A);
    dw(8'h00, 8'h77);
    dw(8'h03, 8'h38);
    dr("ind_wr", 8'h20, 8'h77);
    // Missing bank 2: RAM gone, core registers still answer
    dw(8'h03, 8'h58);
    dr("bank2_ram", 8'h20, 8'h00);
    dr("bank2_core", 8'h04, 8'hA0);
    dw(8'h0A, 8'h08);
    dw(8'h03, 8'h18);
    dr("pc_latch", 8'h0A, 8'h08);
    // Far program address wraps onto the stored word
    mmbd_core_model_inst.wr(`MMBD_APB_PADDR, 32'h00000005);
    mmbd_core_model_inst.wr(`MMBD_APB_PDATA, 32'h00001234);
    dw(8'h02, 8'h05);
    rdchk("pc_load", `MMBD_APB_PC, 32'h00000805);
    rdchk("wrap", `MMBD_APB_PDATA, 32'h00001234);
    // Fetch port shows the same word with no data traffic in the way
    chk("fetch_pc", {19'h0, fetch_pc}, 32'h00000805);
    chk("fetch_word", {18'h0, fetch_word}, 32'h00001234);
    mmbd_core_model_inst.wr(`MMBD_APB_CTRL, 32'h00000002);
    rdchk("irq_vec", `MMBD_APB_PC, 32'h00000004);
    // Run spans three edges: idle edge, then setup and access of the stop
    mmbd_core_model_inst.wr(`MMBD_APB_CTRL, 32'h00000001);
    mmbd_core_model_inst.wr(`MMBD_APB_CTRL, 32'h00000000);
    rdchk("pc_run", `MMBD_APB_PC, 32'h00000007);
    // Address past the map is refused
    mmbd_core_model_inst.rd(12'h01C, rdat, rerr);
    chk("slverr", {31'h00000000, rerr}, 32'h00000001);
    chk("bad_rd", rdat, 32'h00000000);
    print_verdict();
  end
endmodule : mmbd_tb

`default_nettype wire
